/* design/txrc_clock_ctrl.sv */
// Transmit rate and input clock selection with phase alignment
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module txrc_clock_ctrl
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     reference_clock_in,
  input  wire logic                     tx_pll_rate_select,
  input  wire logic                     rx_interface_clock_select,
  input  wire logic [1:0]               tx_input_clock_select,
  input  wire logic                     channel_a_tx_input_clock,
  input  wire logic                     channel_b_tx_input_clock,
  input  wire logic                     channel_c_tx_input_clock,
  input  wire logic                     channel_d_tx_input_clock,
  input  wire logic                     tx_phase_align_reset_n,
  input  wire logic                     rx_recovered_clock_a,
  input  wire logic                     rx_recovered_clock_c,
  output logic [4:0]                    tx_pll_multiplier,
  output logic                          tx_synth_clock_out,
  output logic                          rx_iface_clock_out_a,
  output logic                          rx_iface_clock_out_c,
  output logic [3:0]                    tx_input_load,
  output logic                          tx_phase_aligning,
  output logic                          tx_config_invalid,
  input  wire logic [txrc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [txrc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  import txrc_pkg::*;
  typedef struct packed {
    logic                ref_d;
    logic [3:0]          chan_d;
    logic [1:0]          low_edges;
    logic [7:0]          half_cnt;
    logic [7:0]          half_len;
    logic [7:0]          mid_cnt;
    logic                mid_arm;
    logic [7:0]          syn_cnt;
    logic [3:0][7:0]     phase;
    logic                synth;
    logic                rx_a;
    logic                rx_c;
    logic [4:0]          mult;
    logic [3:0]          load;
    logic                aligning;
    logic                invalid;
    logic [31:0]         ctrl;
    logic                aw_have;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_have;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } txrc_state_t;

  txrc_state_t r;
  txrc_state_t nxt;
  logic [SYNC_W-1:0] pins;

  // Rising edge of a sampled level
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction : rise

  // All pin inputs pass two flip-flops before use
  txrc_sync #(
    .W (SYNC_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({rx_recovered_clock_c, rx_recovered_clock_a,
               tx_phase_align_reset_n, tx_input_clock_select,
               rx_interface_clock_select, tx_pll_rate_select,
               channel_d_tx_input_clock, channel_c_tx_input_clock,
               channel_b_tx_input_clock, channel_a_tx_input_clock,
               reference_clock_in}),
    .q       (pins)
  );

  logic       ref_s;
  logic [3:0] chan_s;
  logic       rate_s;
  logic       rxsel_s;
  logic [1:0] txsel_s;
  logic       align_n_s;
  logic       rec_a_s;
  logic       rec_c_s;

  // Unpack sampled pins
  assign ref_s     = pins[0];
  assign chan_s    = pins[4:1];
  assign rate_s    = pins[5];
  assign rxsel_s   = pins[6];
  assign txsel_s   = pins[8:7];
  assign align_n_s = pins[9];
  assign rec_a_s   = pins[10];
  assign rec_c_s   = pins[11];

  logic       ref_rise;
  logic       ref_fall;
  logic       syn_rise;
  logic [3:0] chan_rise;
  logic       bypass;
  logic       align_low;
  logic       wr_go;
  logic [7:0] sel_ofs;

  // Clock logic and register slave
  always_comb
  begin
    nxt       = r;
    ref_rise  = rise(r.ref_d, ref_s);
    ref_fall  = rise(ref_s, r.ref_d);
    chan_rise = '0;
    for (int i = 0; i < 4; i++)
      chan_rise[i] = rise(r.chan_d[i], chan_s[i]);
    nxt.ref_d  = ref_s;
    nxt.chan_d = chan_s;

    // Multiplier from rate select
    nxt.mult = rate_s ? MULT_HALF_REF : MULT_FULL_REF;
    // Flag for the forbidden pairing
    nxt.invalid = rate_s && (txsel_s != TRI_LOW);

    // Measure ref half period in aclk cycles
    if (ref_rise || ref_fall)
    begin
      nxt.half_cnt = 8'h01;
      nxt.half_len = r.half_cnt;
    end
    else if (r.half_cnt != 8'hFF)
      nxt.half_cnt = r.half_cnt + 8'h01;

    // Synthesized clock: follow ref, or double it
    if (!rate_s)
    begin
      nxt.mid_arm = 1'b0;
      if (ref_rise)
        nxt.synth = 1'b1;
      else if (ref_fall)
        nxt.synth = 1'b0;
    end
    else if (ref_rise || ref_fall)
    begin
      nxt.synth   = 1'b1;
      nxt.mid_arm = 1'b1;
      nxt.mid_cnt = {1'b0, r.half_len[7:1]};
    end
    else if (r.mid_arm)
    begin
      if (r.mid_cnt <= 8'h01)
      begin
        nxt.synth   = 1'b0;
        nxt.mid_arm = 1'b0;
      end
      else
        nxt.mid_cnt = r.mid_cnt - 8'h01;
    end
    syn_rise = rise(r.synth, nxt.synth);

    // Receive interface clocks
    if (!rxsel_s)
    begin
      nxt.rx_a = ref_s;
      nxt.rx_c = ref_s;
    end
    else
    begin
      nxt.rx_a = rec_a_s;
      nxt.rx_c = rec_c_s;
    end

    // Input register clock strobes per channel
    unique case (txsel_s)
      TRI_LOW:  nxt.load = {4{ref_rise}};
      TRI_HIGH: nxt.load = {4{chan_rise[0]}};
      default:  nxt.load = chan_rise;
    endcase

    // Alignment starts after two low samples on ref rising edges
    bypass    = (txsel_s == TRI_LOW) && !rate_s;
    align_low = !align_n_s || r.ctrl[0];
    if (bypass)
      nxt.low_edges = 2'h0;
    else if (ref_rise)
    begin
      if (!align_low)
        nxt.low_edges = 2'h0;
      else if (r.low_edges != ALIGN_LOW_EDGES)
        nxt.low_edges = r.low_edges + 2'h1;
    end
    nxt.aligning = (nxt.low_edges == ALIGN_LOW_EDGES) && align_low;

    // Phase of each input clock against synthesized clock
    nxt.syn_cnt = syn_rise ? 8'h00 : r.syn_cnt + 8'h01;
    for (int i = 0; i < 4; i++)
      if (r.aligning && nxt.load[i])
        nxt.phase[i] = r.syn_cnt;

    // Write channel: address and data in either order
    if (r.bvalid && s_axi_bready)
      nxt.bvalid = 1'b0;
    if (s_axi_awvalid && r.awready)
    begin
      nxt.aw_have = 1'b1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      nxt.w_have = 1'b1;
      nxt.wdata  = s_axi_wdata;
      nxt.wstrb  = s_axi_wstrb;
    end
    wr_go = nxt.aw_have && nxt.w_have && !nxt.bvalid;
    if (wr_go)
    begin
      nxt.aw_have = 1'b0;
      nxt.w_have  = 1'b0;
      nxt.bvalid  = 1'b1;
      nxt.bresp   = RESP_OKAY;
      if (nxt.aw_addr == OFS_CTRL)
      begin
        for (int b = 0; b < 4; b++)
          if (nxt.wstrb[b])
            nxt.ctrl[b*8 +: 8] = nxt.wdata[b*8 +: 8];
        nxt.ctrl[31:1] = '0;                           // Only bit 0 lives
      end
      else if (nxt.aw_addr != OFS_STATUS && nxt.aw_addr != OFS_PHASE)
        nxt.bresp = RESP_SLVERR;
    end
    nxt.awready = !nxt.aw_have && !nxt.bvalid;
    nxt.wready  = !nxt.w_have && !nxt.bvalid;

    // Read channel
    sel_ofs = s_axi_araddr;
    if (r.rvalid && s_axi_rready)
      nxt.rvalid = 1'b0;
    if (s_axi_arvalid && r.arready)
    begin
      nxt.rvalid = 1'b1;
      nxt.rresp  = RESP_OKAY;
      unique case (sel_ofs)
        OFS_CTRL:   nxt.rdata = r.ctrl;
        OFS_STATUS: nxt.rdata = {r.half_len, 6'h00, txsel_s, 3'h0,
                                 r.mult, 3'h0, bypass, r.aligning,
                                 r.invalid, rxsel_s, rate_s};
        OFS_PHASE:  nxt.rdata = r.phase;
        default:
        begin
          nxt.rdata = 32'h0000_0000;
          nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt.arready = !nxt.rvalid;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r          <= '0;
      r.half_len <= HALF_RST;
      r.mult     <= MULT_FULL_REF;
      r.ctrl     <= CTRL_RST;
      r.syn_cnt  <= CNT_RST;
      r.awready  <= 1'b1;
      r.wready   <= 1'b1;
      r.arready  <= 1'b1;
    end
    else
      r <= nxt;
  end

  // Outputs straight from the state register
  assign tx_pll_multiplier    = r.mult;
  assign tx_synth_clock_out   = r.synth;
  assign rx_iface_clock_out_a = r.rx_a;
  assign rx_iface_clock_out_c = r.rx_c;
  assign tx_input_load        = r.load;
  assign tx_phase_aligning    = r.aligning;
  assign tx_config_invalid    = r.invalid;
  assign s_axi_awready        = r.awready;
  assign s_axi_wready         = r.wready;
  assign s_axi_bvalid         = r.bvalid;
  assign s_axi_bresp          = r.bresp;
  assign s_axi_arready        = r.arready;
  assign s_axi_rvalid         = r.rvalid;
  assign s_axi_rdata          = r.rdata;
  assign s_axi_rresp          = r.rresp;
endmodule : txrc_clock_ctrl

/* design/txrc_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module txrc_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } txrc_sync_t;

  txrc_sync_t r;
  txrc_sync_t nxt;

  // First stage feeds only the second
  always_comb
  begin
    nxt.s1 = d;
    nxt.s2 = r.s1;
  end

  // Register stages
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= nxt;
  end

  assign q = r.s2;
endmodule : txrc_sync

/* include/txrc_pkg.sv */
// Constants shared by the transmit clock control block
package txrc_pkg;
  // Three-level select encoding (a floating pin reads as mid)
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_MID  = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  // Transmit PLL multipliers
  localparam logic [4:0] MULT_HALF_REF = 5'h14;  // 20
  localparam logic [4:0] MULT_FULL_REF = 5'h0A;  // 10
  // Reference edges sampled low before alignment starts
  localparam logic [1:0] ALIGN_LOW_EDGES = 2'h2;
  // Register byte offsets
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PHASE  = 8'h08;
  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [7:0]  CNT_RST   = 8'h00;
  localparam logic [7:0]  HALF_RST  = 8'h04;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin sampling vector width
  localparam int SYNC_W = 12;
endpackage : txrc_pkg

/* verif/txrc_clock_ctrl_asserts.sv */
// Port checks for the transmit clock control block
`timescale 1ns/1ns
module txrc_clock_ctrl_asserts
(
  input logic       aclk,
  input logic       aresetn,
  input logic       reference_clock_in,
  input logic       tx_pll_rate_select,
  input logic       rx_interface_clock_select,
  input logic [1:0] tx_input_clock_select,
  input logic       channel_a_tx_input_clock,
  input logic       tx_phase_align_reset_n,
  input logic [4:0] tx_pll_multiplier,
  input logic       tx_synth_clock_out,
  input logic       rx_iface_clock_out_a,
  input logic       rx_iface_clock_out_c,
  input logic [3:0] tx_input_load,
  input logic       tx_phase_aligning
);
  import txrc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       rt, lo, hi, md;
  logic [3:0] held_r;
  // Short names for the static selects
  assign rt = tx_pll_rate_select;
  assign lo = tx_input_clock_select == TRI_LOW;
  assign hi = tx_input_clock_select == TRI_HIGH;
  assign md = tx_input_clock_select == TRI_MID;
  // Cycles the align reset has stayed high
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_phase_align_reset_n)
      held_r <= 4'h0;
    else if (held_r != 4'hF)
      held_r <= held_r + 4'h1;
  end
  property p_mult_hi;
    rt[*5] |-> tx_pll_multiplier == MULT_HALF_REF;
  endproperty
  a_mult_hi: assert property (p_mult_hi)
    else $error("multiplier not twenty");
  property p_mult_lo;
    (!rt)[*5] |-> tx_pll_multiplier == MULT_FULL_REF;
  endproperty
  a_mult_lo: assert property (p_mult_lo)
    else $error("multiplier not ten");
  property p_rx;
    (!rx_interface_clock_select)[*5] |-> rx_iface_clock_out_a ==
      $past(reference_clock_in, 3) && rx_iface_clock_out_c ==
      $past(reference_clock_in, 3);
  endproperty
  a_rx: assert property (p_rx)
    else $error("rx clocks do not follow reference");
  property p_syn_lo;
    (!rt)[*8] |-> tx_synth_clock_out == $past(reference_clock_in, 3);
  endproperty
  a_syn_lo: assert property (p_syn_lo)
    else $error("synth clock not at reference rate");
  property p_syn_hi;
    rt[*8] ##0 $changed(reference_clock_in) |->
      ##[1:5] $rose(tx_synth_clock_out);
  endproperty
  a_syn_hi: assert property (p_syn_hi)
    else $error("synth clock missed a reference edge");
  property p_ld_lo;
    lo[*5] ##0 $rose(reference_clock_in) |-> ##[1:5] tx_input_load == 4'hF;
  endproperty
  a_ld_lo: assert property (p_ld_lo)
    else $error("no load on reference rise");
  property p_ld_hi;
    hi[*5] ##0 $rose(channel_a_tx_input_clock) |->
      ##[1:5] tx_input_load == 4'hF;
  endproperty
  a_ld_hi: assert property (p_ld_hi)
    else $error("no load on channel A rise");
  property p_ld_mid;
    md[*5] ##0 $rose(channel_a_tx_input_clock) |->
      ##[1:5] tx_input_load[0];
  endproperty
  a_ld_mid: assert property (p_ld_mid)
    else $error("no own clock load on channel A rise");
  property p_hold;
    held_r == 4'hF |-> !tx_phase_aligning;
  endproperty
  a_hold: assert property (p_hold)
    else $error("aligning while align reset high");
  property p_bypass;
    (lo && !rt)[*5] |-> !tx_phase_aligning;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("aligning in bypass");
  c_align: cover property ($rose(tx_phase_aligning));
  c_load: cover property (tx_input_load == 4'hF);
  c_fast: cover property (rt && $rose(tx_synth_clock_out));
endmodule : txrc_clock_ctrl_asserts

/* verif/txrc_clock_ctrl_test.sv */
// Self-checking bench for the transmit clock control block
`timescale 1ns/1ns
module txrc_clock_ctrl_test;
  import txrc_pkg::*;
  logic aclk, aresetn, reference_clock_in, tx_pll_rate_select, align_req;
  logic rx_interface_clock_select, tx_phase_align_reset_n, tx_synth_clock_out;
  logic channel_a_tx_input_clock, channel_b_tx_input_clock, seen;
  logic channel_c_tx_input_clock, channel_d_tx_input_clock;
  logic rx_iface_clock_out_a, rx_iface_clock_out_c, tx_phase_aligning;
  logic tx_config_invalid, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] tx_input_clock_select, s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] tx_input_load;
  logic [4:0] tx_pll_multiplier;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, data, exp;
  int failures, n_tests;
  // Rows: rate, rx select, input clock select
  localparam logic [3:0] ROWS [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8,
                                      4'h9, 4'hE};
  txrc_clock_ctrl uut (.aclk, .aresetn, .reference_clock_in,
    .tx_pll_rate_select, .rx_interface_clock_select, .tx_input_clock_select,
    .channel_a_tx_input_clock, .channel_b_tx_input_clock,
    .channel_c_tx_input_clock, .channel_d_tx_input_clock,
    .tx_phase_align_reset_n, .rx_recovered_clock_a(1'b0),
    .rx_recovered_clock_c(1'b0), .tx_pll_multiplier, .tx_synth_clock_out,
    .rx_iface_clock_out_a, .rx_iface_clock_out_c, .tx_input_load,
    .tx_phase_aligning, .tx_config_invalid, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  txrc_host_model host (.rate(tx_pll_rate_select), .align_req,
    .ref_clk(reference_clock_in), .align_n(tx_phase_align_reset_n),
    .tx_clk({channel_d_tx_input_clock, channel_c_tx_input_clock,
             channel_b_tx_input_clock, channel_a_tx_input_clock}));
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Watchdog
  initial
  begin
    #300000;
    failures++;
    report_and_stop();
  end
  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic cfg(input logic [3:0] c);
    tx_pll_rate_select <= c[3];
    rx_interface_clock_select <= c[2];
    tx_input_clock_select <= c[1:0];
    repeat (40) @(posedge aclk);
  endtask : cfg
  task automatic align();
    align_req <= 1'b1;
    seen = 1'b0;
    repeat (80)
    begin
      @(posedge aclk);
      seen |= tx_phase_aligning === 1'b1;
    end
    align_req <= 1'b0;
  endtask : align
  // Main sequence
  initial
  begin
    {aresetn, align_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {tx_pll_rate_select, rx_interface_clock_select, s_axi_wdata} = '0;
    tx_input_clock_select = TRI_LOW;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("mult_rst", 32'(MULT_FULL_REF), 32'(tx_pll_multiplier));
    rd(OFS_CTRL);
    chk("ctrl_rst", CTRL_RST, data);
    // Control write keeps only bit 0
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    chk("wr_ctrl", 32'(RESP_OKAY), 32'(resp));
    rd(OFS_CTRL);
    chk("ctrl_bit0", 32'h1, data);
    // Mid-run reset clears the control register
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL);
    chk("ctrl_rerst", CTRL_RST, data);
    foreach (ROWS[i])
    begin
      cfg(ROWS[i]);
      exp = {14'h0, ROWS[i][1:0], 3'h0,
             ROWS[i][3] ? MULT_HALF_REF : MULT_FULL_REF, 3'h0,
             ROWS[i][1:0] == TRI_LOW && !ROWS[i][3], 1'b0,
             ROWS[i][3] && ROWS[i][1:0] != TRI_LOW, ROWS[i][2], ROWS[i][3]};
      chk("mult", 32'(exp[12:8]), 32'(tx_pll_multiplier));
      chk("invalid", 32'(exp[2]), 32'(tx_config_invalid));
      rd(OFS_STATUS);
      chk("status", exp, data & 32'h0003_1F17);
    end
    // Unmapped and read-only accesses
    wr(8'h10, 32'h0000_0001);
    chk("wr_unmapped", 32'(RESP_SLVERR), 32'(resp));
    rd(8'h3C);
    chk("rd_unmapped_resp", 32'(RESP_SLVERR), 32'(resp));
    chk("rd_unmapped_data", 32'h0000_0000, data);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    chk("wr_status", 32'(RESP_OKAY), 32'(resp));
    // Alignment with own input clocks, then hold
    cfg(4'h1);
    align();
    chk("aligning", 32'h1, 32'(seen));
    repeat (40) @(posedge aclk);
    chk("held", 32'h0, 32'(tx_phase_aligning));
    // Bypass ignores the align reset
    cfg(4'h0);
    align();
    chk("bypass", 32'h0, 32'(seen));
    report_and_stop();
  end
endmodule : txrc_clock_ctrl_test
bind txrc_clock_ctrl txrc_clock_ctrl_asserts u_chk (.aclk, .aresetn,
  .reference_clock_in, .tx_pll_rate_select, .rx_interface_clock_select,
  .tx_input_clock_select, .channel_a_tx_input_clock,
  .tx_phase_align_reset_n, .tx_pll_multiplier, .tx_synth_clock_out,
  .rx_iface_clock_out_a, .rx_iface_clock_out_c, .tx_input_load,
  .tx_phase_aligning);

/* verif/txrc_host_model.sv */
// Host side model: reference, input clocks and align reset
`timescale 1ns/1ns
module txrc_host_model (
  input  logic       rate,
  input  logic       align_req,
  output logic       ref_clk,
  output logic [3:0] tx_clk,
  output logic       align_n
);
  // Free running reference, 160 ns period
  initial
  begin
    ref_clk = 1'b0;
    #7;
    forever #80 ref_clk = ~ref_clk;
  end
  // Input clocks at the synthesized rate, fixed phase steps
  for (genvar g = 0; g < 4; g++)
  begin : g_ch
    initial
    begin
      tx_clk[g] = 1'b0;
      #(13 + 10 * g);
      forever #(rate ? 40 : 80) tx_clk[g] = ~tx_clk[g];
    end
  end
  // Align reset held low across three reference rises
  initial
  begin
    align_n = 1'b1;
    forever
    begin
      @(posedge align_req);
      align_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #30 align_n = 1'b1;
    end
  end
endmodule : txrc_host_model
